// ==== shared/wake_pkg.sv ====
// Constants for the remote wake unit: register offsets, field positions,
// reset values and the layout of a pattern storage word.
// Assumes a byte-addressed register port with 32-bit data words.
package wake_pkg;

  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_ADDR_LOW = 5'h04;
  localparam logic [4:0] OFS_ADDR_HIGH = 5'h08;
  localparam logic [4:0] OFS_POINTER = 5'h0C;
  localparam logic [4:0] OFS_LEN_LOW = 5'h10;
  localparam logic [4:0] OFS_LEN_HIGH = 5'h14;
  localparam logic [4:0] OFS_CNT_LOW = 5'h18;
  localparam logic [4:0] OFS_CNT_HIGH = 5'h1C;

  // Word at OFS_CTRL
  localparam int BIT_LC_STATUS = 15;
  localparam int BIT_MP_STATUS = 14;
  localparam int BIT_WF_STATUS = 13;
  localparam int BIT_CLEAR = 12;
  localparam int BIT_LC_PME_ON = 11;
  localparam int BIT_LC_PME_OFF = 10;
  localparam int BIT_MP_PME_ON = 9;
  localparam int BIT_MP_PME_OFF = 8;
  localparam int BIT_WF_PME_ON = 7;
  localparam int BIT_WF_PME_OFF = 6;
  localparam int BIT_LC_UNIT_ON = 5;
  localparam int BIT_LC_UNIT_OFF = 4;
  localparam int BIT_MP_UNIT_ON = 3;
  localparam int BIT_MP_UNIT_OFF = 2;
  localparam int BIT_WF_UNIT_ON = 1;
  localparam int BIT_WF_UNIT_OFF = 0;
  localparam int PAT_EN_LSB = 16;
  localparam int MATCH_LSB = 24;

  // Word at OFS_ADDR_HIGH
  localparam int EVT_EN_LSB = 16;
  localparam int BIT_FORCE = 23;

  localparam int NUM_PATTERNS = 7;
  localparam int FIELD_W = 7;
  localparam int FIELD_STRIDE = 8;
  localparam int FIELDS_LOW = 4;

  localparam logic PAIR_RESET = 1'b0;
  localparam logic [6:0] FIELD_RESET = 7'h00;
  localparam logic [47:0] ADDR_RESET = 48'h0;

  // Pattern word: byte of pattern p at [8p+7:8p], compare mask at 64+p
  localparam int PAT_WORD_W = 128;
  localparam int PAT_MASK_LSB = 64;

  localparam logic [7:0] MAGIC_SYNC_VALUE = 8'hFF;
  localparam logic [2:0] MAGIC_SYNC_BYTES = 3'h6;
  localparam logic [2:0] ADDR_LAST_BYTE = 3'h5;
  localparam logic [3:0] MAGIC_LAST_REPEAT = 4'hF;

  typedef enum logic [0:0] {MP_SYNC, MP_ADDR} magic_state_e;

endpackage

// ==== hw/magic_detect.sv ====
// Magic packet detector: six sync bytes then the station address 16 times.
// Assumes a byte stream on the core clock with a start marker on byte 0.
`timescale 1ns/100ps
`default_nettype none
module magic_detect
  import wake_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic sof,
  input wire logic valid,
  input wire logic [7:0] data,
  input wire logic [47:0] addr,
  output logic hit
);
  magic_state_e state;
  logic [2:0] sync_cnt;
  logic [2:0] byte_idx;
  logic [3:0] rep;
  magic_state_e cur_state;
  logic [2:0] cur_sync;

  // A start marker restarts the search even in the middle of a sequence
  assign cur_state = sof ? MP_SYNC : state;
  assign cur_sync = sof ? 3'h0 : sync_cnt;

  function automatic logic [7:0] addr_byte(input logic [47:0] a,
                                           input logic [2:0] i);
    addr_byte = a[{i, 3'h0} +: 8];
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= MP_SYNC;
      sync_cnt <= 3'h0;
      byte_idx <= 3'h0;
      rep <= 4'h0;
      hit <= 1'b0;
    end else begin
      hit <= 1'b0;
      if (!enable) begin
        state <= MP_SYNC;
        sync_cnt <= 3'h0;
      end else if (valid) begin
        case (cur_state)
          MP_SYNC: begin
            state <= MP_SYNC;
            if (cur_sync == MAGIC_SYNC_BYTES
                && data == addr_byte(addr, 3'h0)) begin
              state <= MP_ADDR;
              byte_idx <= 3'h1;
              rep <= 4'h0;
            end else if (data == MAGIC_SYNC_VALUE) begin
              if (cur_sync != MAGIC_SYNC_BYTES) begin
                sync_cnt <= cur_sync + 3'h1;
              end else begin
                sync_cnt <= cur_sync;
              end
            end else begin
              sync_cnt <= 3'h0;
            end
          end
          MP_ADDR: begin
            if (data == addr_byte(addr, byte_idx)) begin
              if (byte_idx == ADDR_LAST_BYTE) begin
                byte_idx <= 3'h0;
                if (rep == MAGIC_LAST_REPEAT) begin
                  hit <= 1'b1; // RQ9
                  state <= MP_SYNC;
                  sync_cnt <= 3'h0;
                end else begin
                  rep <= rep + 4'h1;
                end
              end else begin
                byte_idx <= byte_idx + 3'h1;
              end
            end else begin
              state <= MP_SYNC;
              sync_cnt <= (data == MAGIC_SYNC_VALUE) ? 3'h1 : 3'h0;
            end
          end
          default: begin
            state <= MP_SYNC;
            sync_cnt <= 3'h0;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== hw/pattern_track.sv ====
// Progress tracker for one stored pattern against the incoming frame.
// Assumes the pattern byte for the current frame position is presented
// in the same cycle as the received byte.
`timescale 1ns/100ps
`default_nettype none
module pattern_track (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic sof,
  input wire logic valid,
  input wire logic [7:0] data,
  input wire logic [7:0] pat_byte,
  input wire logic pat_mask,
  input wire logic [6:0] len,
  output logic [6:0] count,
  output logic hit
);
  logic alive;
  logic [6:0] pos;
  logic live;
  logic same;

  assign pos = sof ? 7'h00 : count;
  assign live = sof | alive;
  assign same = !pat_mask || (data == pat_byte);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 7'h00; // RQ17
      alive <= 1'b0;
      hit <= 1'b0;
    end else begin
      hit <= 1'b0;
      if (valid) begin
        if (!enable) begin
          if (sof) begin
            count <= 7'h00;
            alive <= 1'b0;
          end
        end else if (live) begin // RQ1
          count <= pos; // RQ17
          if (!same) begin
            alive <= 1'b0;
          end else if (pos == len) begin // RQ15
            hit <= 1'b1;
            alive <= 1'b0;
          end else begin
            count <= pos + 7'h01;
            alive <= 1'b1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== hw/remote_wake_unit.sv ====
// Remote wake unit: register file, wake sources, status and event request.
// Assumes receive bytes and the configuration event enable arrive on MCLK;
// the link-up level comes from outside and is synchronised here.
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RQ1: Compare a stored pattern only while its enable bit 22..16 is set.
// RQ2: Status bits 15,14,13 set on link, magic, frame wake; writes ignored.
// RQ3: Writing bit 12 clears magic, link status and match bits; reads zero.
// RQ4: Pair control: upper bit on, lower bit off; reads 10 or 01; resets off.
// RQ5: Link change event asserts PME# when pair 11/10 on and PME enable set.
// RQ6: Magic packet event asserts PME# when pair 9/8 on and PME enable set.
// RQ7: Wake frame event asserts PME# when pair 7/6 on and PME enable set.
// RQ8: Link change unit on: each link-up sets link status and may raise PME#.
// RQ9: Magic unit on: each packet checked for magic pattern; hit sets status.
// RQ10: Frame unit on: packets compared with enabled patterns; hit sets match.
// RQ11: Writing bit 23 of event enable forces an event; bit reads zero.
// RQ12: Pattern match raises an event only if its event enable bit is set.
// RQ13: Station address held as high bytes 5,4 and low bytes 3..0.
// RQ14: Seven-bit pointer to the pattern word compared; writable for test.
// RQ15: Length field holds bytes to compare minus one; resets to zero.
// RQ16: Software never programs a pattern shorter than six bytes.
// RQ17: Read-only seven-bit progress counter per pattern; resets to zero.
// RQ18: Patterns 4..6 fields in second register, patterns 0..3 in first.
// RQ19: Match bits 30..24 show the last packet matched pattern 6..0.
// RQ20: Reset forces the whole unit and its registers to reset state.
// RQ21: Software turns frame matching off before touching pattern storage.
// RQ22: Flags stay set until clear or reset; request is OR of gated sources. Frame status clears only on reset, not on the clear.
module remote_wake_unit
  import wake_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [4:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic RX_VALID,
  input wire logic RX_SOF,
  input wire logic RX_EOF,
  input wire logic [7:0] RX_DATA,
  input wire logic LINK_UP,
  input wire logic PME_EN,
  output logic [6:0] PAT_ADDR,
  input wire logic [PAT_WORD_W-1:0] PAT_WORD,
  output logic PME_N
);
  localparam int NP = NUM_PATTERNS;

  logic lc_pme_on;
  logic mp_pme_on;
  logic wf_pme_on;
  logic lc_unit_on;
  logic mp_unit_on;
  logic wf_unit_on;
  logic lc_status;
  logic mp_status;
  logic wf_status;
  logic forced;
  logic [NP-1:0] pat_en;
  logic [NP-1:0] evt_en;
  logic [NP-1:0] match;
  logic [47:0] station;
  logic [6:0] pointer;
  logic [NP*FIELD_W-1:0] lens;
  logic [NP*FIELD_W-1:0] counts;
  logic [NP-1:0] pat_hit;
  logic magic_hit;
  logic link_meta;
  logic link_sync;
  logic link_prev;
  logic link_rise;
  logic wr_ctrl;
  logic wr_high;
  logic clear;
  logic pme_req;
  logic [31:0] next_rdata;

  // Pair write: on wins over off if software sets both
  function automatic logic pair_next(input logic cur, input logic on,
                                     input logic off);
    pair_next = on ? 1'b1 : (off ? 1'b0 : cur);
  endfunction

  function automatic logic [1:0] pair_read(input logic on);
    pair_read = {on, ~on};
  endfunction

  // Place per-pattern fields at byte lanes, starting from pattern base
  function automatic logic [31:0] pack_fields(
      input logic [NP*FIELD_W-1:0] flat, input int base, input int n);
    logic [31:0] w;
    w = 32'h0;
    for (int i = 0; i < n; i++) begin
      w[i*FIELD_STRIDE +: FIELD_W] = flat[(base+i)*FIELD_W +: FIELD_W];
    end
    pack_fields = w;
  endfunction

  assign wr_ctrl = WR && (ADDR == OFS_CTRL);
  assign wr_high = WR && (ADDR == OFS_ADDR_HIGH);
  assign clear = wr_ctrl && WDATA[BIT_CLEAR]; // RQ3

  // Link level comes from the PHY side; the first stage feeds only the second
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      link_meta <= 1'b0;
      link_sync <= 1'b0;
      link_prev <= 1'b0;
    end else begin
      link_meta <= LINK_UP;
      link_sync <= link_meta;
      link_prev <= link_sync;
    end
  end

  assign link_rise = link_sync && !link_prev;

  // Pair controls
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      lc_pme_on <= PAIR_RESET; // RQ20
      mp_pme_on <= PAIR_RESET;
      wf_pme_on <= PAIR_RESET;
      lc_unit_on <= PAIR_RESET;
      mp_unit_on <= PAIR_RESET;
      wf_unit_on <= PAIR_RESET;
    end else if (wr_ctrl) begin
      lc_pme_on <= pair_next(lc_pme_on, WDATA[BIT_LC_PME_ON],
                             WDATA[BIT_LC_PME_OFF]); // RQ4
      mp_pme_on <= pair_next(mp_pme_on, WDATA[BIT_MP_PME_ON],
                             WDATA[BIT_MP_PME_OFF]); // RQ4
      wf_pme_on <= pair_next(wf_pme_on, WDATA[BIT_WF_PME_ON],
                             WDATA[BIT_WF_PME_OFF]); // RQ4
      lc_unit_on <= pair_next(lc_unit_on, WDATA[BIT_LC_UNIT_ON],
                              WDATA[BIT_LC_UNIT_OFF]); // RQ4
      mp_unit_on <= pair_next(mp_unit_on, WDATA[BIT_MP_UNIT_ON],
                              WDATA[BIT_MP_UNIT_OFF]); // RQ4
      wf_unit_on <= pair_next(wf_unit_on, WDATA[BIT_WF_UNIT_ON],
                              WDATA[BIT_WF_UNIT_OFF]); // RQ4
    end
  end

  // Plain read/write registers
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pat_en <= '0;
      evt_en <= '0;
      station <= ADDR_RESET;
      lens <= '0; // RQ15
    end else if (WR) begin
      case (ADDR)
        OFS_CTRL: begin
          pat_en <= WDATA[PAT_EN_LSB +: NP]; // RQ1
        end
        OFS_ADDR_HIGH: begin
          station[47:32] <= WDATA[15:0]; // RQ13
          evt_en <= WDATA[EVT_EN_LSB +: NP]; // RQ12
        end
        OFS_ADDR_LOW: begin
          station[31:0] <= WDATA; // RQ13
        end
        OFS_LEN_LOW: begin
          for (int i = 0; i < FIELDS_LOW; i++) begin
            lens[i*FIELD_W +: FIELD_W] <=
                WDATA[i*FIELD_STRIDE +: FIELD_W]; // RQ18
          end
        end
        OFS_LEN_HIGH: begin
          for (int i = 0; i < NP - FIELDS_LOW; i++) begin
            lens[(FIELDS_LOW+i)*FIELD_W +: FIELD_W] <=
                WDATA[i*FIELD_STRIDE +: FIELD_W]; // RQ18
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Pointer follows the frame; a test write overrides the receive path
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pointer <= FIELD_RESET;
    end else if (WR && ADDR == OFS_POINTER) begin
      pointer <= WDATA[6:0]; // RQ14
    end else if (RX_VALID) begin
      if (RX_EOF) begin
        pointer <= 7'h00;
      end else if (RX_SOF) begin
        pointer <= 7'h01; // RQ14
      end else if (pointer != 7'h7F) begin
        pointer <= pointer + 7'h01; // RQ14
      end
    end
  end

  assign PAT_ADDR = pointer;

  magic_detect magic (
    .clk(MCLK),
    .rst(RST),
    .enable(mp_unit_on), // RQ9
    .sof(RX_SOF),
    .valid(RX_VALID),
    .data(RX_DATA),
    .addr(station),
    .hit(magic_hit)
  );

  for (genvar p = 0; p < NP; p++) begin : track
    pattern_track tracker (
      .clk(MCLK),
      .rst(RST),
      .enable(wf_unit_on && pat_en[p]), // RQ10
      .sof(RX_SOF),
      .valid(RX_VALID),
      .data(RX_DATA),
      .pat_byte(PAT_WORD[p*8 +: 8]),
      .pat_mask(PAT_WORD[PAT_MASK_LSB + p]),
      .len(lens[p*FIELD_W +: FIELD_W]),
      .count(counts[p*FIELD_W +: FIELD_W]),
      .hit(pat_hit[p])
    );
  end

  // Sticky flags; a set in the same cycle as the clear wins
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      lc_status <= 1'b0;
    end else if (lc_unit_on && link_rise) begin
      lc_status <= 1'b1; // RQ8
    end else if (clear) begin
      lc_status <= 1'b0; // RQ3
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      mp_status <= 1'b0;
    end else if (mp_unit_on && magic_hit) begin
      mp_status <= 1'b1; // RQ9
    end else if (clear) begin
      mp_status <= 1'b0; // RQ3
    end
  end

  // Frame status is not touched by the clear command, only by reset
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      wf_status <= 1'b0;
    end else if (wf_unit_on && |pat_hit) begin
      wf_status <= 1'b1; // RQ2
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      match <= '0;
    end else begin
      for (int i = 0; i < NP; i++) begin
        if (pat_hit[i]) begin
          match[i] <= 1'b1; // RQ19
        end else if (clear) begin
          match[i] <= 1'b0; // RQ3
        end
      end
    end
  end

  // Forced event holds until the clear command so the host can see it
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      forced <= 1'b0;
    end else if (wr_high && WDATA[BIT_FORCE]) begin
      forced <= 1'b1; // RQ11
    end else if (clear) begin
      forced <= 1'b0;
    end
  end

  // RQ22
  assign pme_req = forced
      || (PME_EN && lc_pme_on && lc_status) // RQ5
      || (PME_EN && mp_pme_on && mp_status) // RQ6
      || (PME_EN && wf_pme_on && |(match & evt_en)); // RQ7 RQ12

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PME_N <= 1'b1;
    end else begin
      PME_N <= !pme_req;
    end
  end

  // Read mux; unmapped addresses and command bits read zero
  always_comb begin
    next_rdata = 32'h0;
    case (ADDR)
      OFS_CTRL: begin
        next_rdata[MATCH_LSB +: NP] = match; // RQ19
        next_rdata[PAT_EN_LSB +: NP] = pat_en;
        next_rdata[BIT_LC_STATUS] = lc_status; // RQ2
        next_rdata[BIT_MP_STATUS] = mp_status; // RQ2
        next_rdata[BIT_WF_STATUS] = wf_status; // RQ2
        next_rdata[BIT_LC_PME_ON -: 2] = pair_read(lc_pme_on); // RQ4
        next_rdata[BIT_MP_PME_ON -: 2] = pair_read(mp_pme_on); // RQ4
        next_rdata[BIT_WF_PME_ON -: 2] = pair_read(wf_pme_on); // RQ4
        next_rdata[BIT_LC_UNIT_ON -: 2] = pair_read(lc_unit_on); // RQ4
        next_rdata[BIT_MP_UNIT_ON -: 2] = pair_read(mp_unit_on); // RQ4
        next_rdata[BIT_WF_UNIT_ON -: 2] = pair_read(wf_unit_on); // RQ4
      end
      OFS_ADDR_LOW: begin
        next_rdata = station[31:0];
      end
      OFS_ADDR_HIGH: begin
        next_rdata[15:0] = station[47:32];
        next_rdata[EVT_EN_LSB +: NP] = evt_en;
      end
      OFS_POINTER: begin
        next_rdata[6:0] = pointer;
      end
      OFS_LEN_LOW: begin
        next_rdata = pack_fields(lens, 0, FIELDS_LOW); // RQ18
      end
      OFS_LEN_HIGH: begin
        next_rdata = pack_fields(lens, FIELDS_LOW, NP - FIELDS_LOW);
      end
      OFS_CNT_LOW: begin
        next_rdata = pack_fields(counts, 0, FIELDS_LOW); // RQ17
      end
      OFS_CNT_HIGH: begin
        next_rdata = pack_fields(counts, FIELDS_LOW, NP - FIELDS_LOW);
      end
      default: begin
        next_rdata = 32'h0;
      end
    endcase
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      RDATA <= 32'h0;
    end else if (RD) begin
      RDATA <= next_rdata;
    end else begin
      RDATA <= 32'h0;
    end
  end
endmodule
`default_nettype wire

// ==== verif/wake_unit_sva.sv ====
// Port checker for the remote wake unit.
// Assumes one clock domain, bound to remote_wake_unit.
`timescale 1ns/100ps
`default_nettype none
module wake_unit_sva
  import wake_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [4:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic RX_VALID,
  input wire logic RX_SOF,
  input wire logic RX_EOF,
  input wire logic PME_EN,
  input wire logic [6:0] PAT_ADDR,
  input wire logic PME_N
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  logic ptr_wr;
  logic [6:0] wlow;
  assign ptr_wr = WR && ADDR == OFS_POINTER;
  assign wlow = WDATA[6:0];
  sequence s_force;
    WR && ADDR == OFS_ADDR_HIGH && WDATA[BIT_FORCE];
  endsequence
  sequence s_rx_mid;
    RX_VALID && !RX_SOF && !RX_EOF && !ptr_wr;
  endsequence
  a_reset_state: assert property (
    $fell(RST) |-> PME_N && PAT_ADDR == 7'h00 && RDATA == 32'h0)
    else $error("outputs not at reset values");
  a_ctrl_pairs: assert property (
    RD && ADDR == OFS_CTRL |=> !RDATA[12] && RDATA[11] != RDATA[10]
    && RDATA[9] != RDATA[8] && RDATA[7] != RDATA[6]
    && RDATA[5] != RDATA[4] && RDATA[3] != RDATA[2]
    && RDATA[1] != RDATA[0]) else $error("control word malformed");
  a_force_zero: assert property (
    RD && ADDR == OFS_ADDR_HIGH |=> !RDATA[BIT_FORCE])
    else $error("force bit read as one");
  a_force_event: assert property (
    s_force |=> ##1 !PME_N) else $error("force gave no event");
  a_ptr_test: assert property (
    ptr_wr |=> PAT_ADDR == $past(wlow)) else $error("pointer write lost");
  a_ptr_sof: assert property (
    RX_VALID && RX_SOF && !RX_EOF && !ptr_wr |=> PAT_ADDR == 7'h01)
    else $error("pointer not restarted");
  a_ptr_eof: assert property (
    RX_VALID && RX_EOF && !ptr_wr |=> PAT_ADDR == 7'h00)
    else $error("pointer not cleared at end");
  a_ptr_step: assert property (
    s_rx_mid |=> PAT_ADDR == ($past(PAT_ADDR) == 7'h7F ? 7'h7F
    : $past(PAT_ADDR) + 7'h01)) else $error("pointer step wrong");
  a_len_resv: assert property (
    RD && (ADDR == OFS_LEN_LOW || ADDR == OFS_CNT_LOW)
    |=> (RDATA & 32'h80808080) == 32'h0) else $error("reserved bit set");
  a_pme_hold: assert property (
    !PME_N && PME_EN && $past(PME_EN) && !WR && !$past(WR) |=> !PME_N)
    else $error("event request dropped");
endmodule
bind remote_wake_unit wake_unit_sva wake_unit_sva_inst (.MCLK(MCLK),
  .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .RX_VALID(RX_VALID), .RX_SOF(RX_SOF), .RX_EOF(RX_EOF),
  .PME_EN(PME_EN), .PAT_ADDR(PAT_ADDR), .PME_N(PME_N));
`default_nettype wire

// ==== verif/pattern_store_model.sv ====
// Pattern storage standing at the far side of the unit.
// Assumes the bench loads it only while frame matching is off.
`timescale 1ns/100ps
`default_nettype none
module pattern_store_model
  import wake_pkg::*;
(
  input wire logic clk,
  input wire logic load,
  input wire logic [6:0] load_addr,
  input wire logic [PAT_WORD_W-1:0] load_word,
  input wire logic [6:0] pat_addr,
  output logic [PAT_WORD_W-1:0] pat_word
);
  logic [PAT_WORD_W-1:0] mem [0:127] = '{default: '0};
  always_ff @(posedge clk) begin
    if (load) begin
      mem[load_addr] <= load_word;
    end
  end
  // Read is combinational: the unit samples it in the same cycle
  assign pat_word = mem[pat_addr];
endmodule
`default_nettype wire

// ==== verif/remote_wake_unit_tb.sv ====
// Self-checking bench for the remote wake unit.
// Assumes the pattern store model and the bound port checker.
`timescale 1ns/100ps
`default_nettype none
module remote_wake_unit_tb;
  import wake_pkg::*;
  typedef struct {logic [4:0] a; logic w; logic [31:0] d, e;} row_s;
  logic mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, load = 1'b0;
  logic rx_valid = 1'b0, rx_sof = 1'b0, rx_eof = 1'b0, link_up = 1'b0;
  logic pme_en = 1'b0, pme_n;
  logic [4:0] addr = '0;
  logic [31:0] wdata = '0, rdata, got;
  logic [7:0] rx_data = 8'h00;
  logic [6:0] pat_addr, load_addr = '0;
  logic [PAT_WORD_W-1:0] pat_word, load_word = '0, w;
  logic [7:0] frame [$];
  int errors = 0, total_checks = 0, cycles = 0;
  row_s rows [0:20];
  remote_wake_unit remote_wake_unit_inst (.MCLK(mclk), .RST(rst),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .RX_VALID(rx_valid), .RX_SOF(rx_sof), .RX_EOF(rx_eof),
    .RX_DATA(rx_data), .LINK_UP(link_up), .PME_EN(pme_en),
    .PAT_ADDR(pat_addr), .PAT_WORD(pat_word), .PME_N(pme_n));
  pattern_store_model pattern_store_model_inst (.clk(mclk), .load(load),
    .load_addr(load_addr), .load_word(load_word), .pat_addr(pat_addr),
    .pat_word(pat_word));
  initial begin
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t event pin %b expected %b", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    got = rdata;
  endtask
  task automatic send_frame();
    foreach (frame[i]) begin
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_sof <= (i == 0);
      rx_eof <= (i == frame.size() - 1);
      rx_data <= frame[i];
    end
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_eof <= 1'b0;
    rx_data <= ~rx_data;
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task automatic wait_pin(input logic e);
    repeat (3) @(posedge mclk);
    #1;
    chk_pin(pme_n, e);
  endtask
  initial begin
    rows = '{'{OFS_CTRL, 0, 0, 32'h555}, '{OFS_ADDR_LOW, 0, 0, 0},
      '{OFS_ADDR_HIGH, 0, 0, 0}, '{OFS_POINTER, 0, 0, 0},
      '{OFS_LEN_LOW, 0, 0, 0}, '{OFS_LEN_HIGH, 0, 0, 0},
      '{OFS_CNT_LOW, 0, 0, 0}, '{OFS_CNT_HIGH, 0, 0, 0},
      '{OFS_CTRL, 1, 32'hFF80F000, 32'h555},
      '{OFS_CTRL, 1, 32'h007F0FFF, 32'h007F0AAA},
      '{OFS_CTRL, 1, 32'h555, 32'h555},
      '{OFS_ADDR_LOW, 1, 32'h33221100, 32'h33221100},
      '{OFS_ADDR_HIGH, 1, 32'h007F5544, 32'h007F5544},
      '{OFS_POINTER, 1, 32'hFFFFFFFF, 32'h7F}, '{OFS_POINTER, 1, 0, 0},
      '{OFS_LEN_LOW, 1, 32'hFFFFFFFF, 32'h7F7F7F7F},
      '{OFS_LEN_HIGH, 1, 32'hFFFFFFFF, 32'h007F7F7F},
      '{OFS_CNT_LOW, 1, 32'hFFFFFFFF, 0}, '{OFS_CNT_HIGH, 1, 32'hFF, 0},
      '{5'h02, 1, 32'hFFFFFFFF, 0}, '{OFS_CTRL, 0, 0, 32'h555}};
    repeat (19) @(posedge mclk);
    #1;
    chk_pin(pme_n, 1'b1);
    @(posedge mclk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr_reg(rows[i].a, rows[i].d);
      end
      rd_reg(rows[i].a);
      chk(got, rows[i].e);
    end
    // Lengths of six bytes, the shortest allowed
    wr_reg(OFS_ADDR_HIGH, 32'h00015544);
    wr_reg(OFS_LEN_LOW, 32'h05050505);
    wr_reg(OFS_LEN_HIGH, 32'h00050505);
    for (int i = 0; i < 6; i++) begin
      w = '0;
      w[66:64] = 3'h7;
      w[7:0] = 8'hA0 + 8'(i);
      w[15:8] = (i == 3) ? 8'h00 : w[7:0];
      w[23:16] = w[7:0];
      load <= 1'b1;
      load_addr <= 7'(i);
      load_word <= w;
      @(posedge mclk);
    end
    load <= 1'b0;
    wr_reg(OFS_CTRL, 32'h00030082);
    pme_en <= 1'b1;
    frame = {};
    for (int i = 0; i < 8; i++) frame.push_back(8'hA0 + 8'(i));
    send_frame();
    chk_pin(pme_n, 1'b0);
    rd_reg(OFS_CTRL);
    chk(got, 32'h01032596);
    rd_reg(OFS_CNT_LOW);
    chk(got & 32'h7F, 32'h5);
    @(posedge mclk);
    pme_en <= 1'b0;
    wait_pin(1'b1);
    @(posedge mclk);
    pme_en <= 1'b1;
    wr_reg(OFS_ADDR_HIGH, 32'h00005544);
    wait_pin(1'b1);
    wr_reg(OFS_CTRL, 32'h1000);
    rd_reg(OFS_CTRL);
    chk(got, 32'h00002596);
    wr_reg(OFS_CTRL, 32'h0208);
    for (int k = 15; k <= 16; k++) begin
      frame = {};
      repeat (6) frame.push_back(8'hFF);
      repeat (k) for (int b = 0; b < 6; b++) frame.push_back(8'(b) * 8'h11);
      send_frame();
      rd_reg(OFS_CTRL);
      chk(got, (k == 16) ? 32'h0000669A : 32'h0000269A);
      chk_pin(pme_n, k != 16);
    end
    wr_reg(OFS_CTRL, 32'h1820);
    wait_pin(1'b1);
    @(posedge mclk);
    link_up <= 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    chk_pin(pme_n, 1'b0);
    rd_reg(OFS_CTRL);
    chk(got, 32'h0000AAAA);
    wr_reg(OFS_CTRL, 32'h1000);
    wait_pin(1'b1);
    @(posedge mclk);
    pme_en <= 1'b0;
    wr_reg(OFS_ADDR_HIGH, 32'h00805544);
    @(posedge mclk);
    #1;
    chk_pin(pme_n, 1'b0);
    rd_reg(OFS_ADDR_HIGH);
    chk(got, 32'h00005544);
    wr_reg(OFS_CTRL, 32'h1000);
    wait_pin(1'b1);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk_pin(pme_n, 1'b1);
    @(posedge mclk);
    rst <= 1'b0;
    rd_reg(OFS_CTRL);
    chk(got, 32'h555);
    rd_reg(OFS_ADDR_LOW);
    chk(got, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
